/* File: core/temp_sensor_i2c_slave_port.sv */
// two-wire serial slave port of the temperature sensor
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_i2c_slave_port #(
   parameter int RELOAD_CYCLES = temp_sensor_pkg::RELOAD_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe_n,
   input  wire logic       address_strap_bit0,
   input  wire logic       address_strap_bit1,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   input  wire logic [7:0] reg_rdata,
   output var  logic       defaults_reload,
   output var  logic       alarm_clear,
   output var  logic       reload_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [3:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic [1:0] strap_s;

   logic       scl_prev_reg;
   logic       sda_prev_reg;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;

   bit_sync #(.WIDTH(4)) i_bit_sync (
      .clock    (clock),
      .rstn     (rstn),
      .data_in  ({scl_in, sda_in, address_strap_bit1, address_strap_bit0}),
      .data_out (pins_sync)
   );

   assign scl_s   = pins_sync[3];
   assign sda_s   = pins_sync[2];
   assign strap_s = pins_sync[1:0];

   // idle-high reset: no false edge after reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_prev_reg;
   assign scl_fall   = ~scl_s & scl_prev_reg;

   // both lines pass the same synchroniser depth, so skew stays equal
   assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_seen  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // default reload timer
   // no new acknowledge starts while this runs
   reload_if reload_bus ();

   reload_timer #(.RELOAD_CYCLES(RELOAD_CYCLES)) i_reload_timer (
      .clock (clock),
      .rstn  (rstn),
      .ctl   (reload_bus.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // own address and pair decode
   logic [6:0] own_addr;
   logic       rx_is_own;
   logic       rx_is_gc;

   assign own_addr  = {temp_sensor_pkg::ADDR_FIXED_BITS, strap_s};

   // only pair uppers auto-increment
   function automatic logic is_pair_upper(input logic [7:0] a);
      is_pair_upper = (a == temp_sensor_pkg::TEMP_UPPER) ||
                      (a == temp_sensor_pkg::HIGH_UPPER) ||
                      (a == temp_sensor_pkg::LOWER_UPPER) ||
                      (a == temp_sensor_pkg::CRIT_UPPER);
   endfunction : is_pair_upper

   ////////////////////////////////////////////////////////////////////////////
   // protocol engine
   temp_sensor_pkg::link_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;

   // frame context: direction and general call from the address byte; byte index stepped by data bytes
   logic       read_dir_reg;
   logic       gc_reg;
   logic [1:0] byte_idx_reg;

   // kept across frames; the pair step uses a copy
   logic [7:0] pointer_reg;
   logic [7:0] cur_addr_reg;
   logic       pair_reg;
   logic       more_reg;
   logic       reload_start_reg;

   assign rx_is_own = (shift_reg[7:1] == own_addr);
   assign rx_is_gc  = (shift_reg[7:1] == temp_sensor_pkg::GENERAL_CALL) &
                      ~shift_reg[0];

   assign reload_bus.start = reload_start_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg        <= temp_sensor_pkg::ST_IDLE;
         bit_cnt_reg      <= 4'h0;
         shift_reg        <= 8'h00;
         tx_reg           <= 8'hFF;
         read_dir_reg     <= 1'b0;
         gc_reg           <= 1'b0;
         byte_idx_reg     <= temp_sensor_pkg::IDX_POINTER;
         pointer_reg      <= temp_sensor_pkg::POINTER_RESET;
         cur_addr_reg     <= temp_sensor_pkg::POINTER_RESET;
         pair_reg         <= 1'b0;
         more_reg         <= 1'b0;
         reload_start_reg <= 1'b0;
         sda_oe_n         <= 1'b1;
         reg_addr         <= temp_sensor_pkg::POINTER_RESET;
         reg_wdata        <= 8'h00;
         reg_wr           <= 1'b0;
         reg_rd           <= 1'b0;
      end else begin
         reg_wr           <= 1'b0;
         reg_rd           <= 1'b0;
         reload_start_reg <= 1'b0;
         // stop and start override any state
         if (stop_seen) begin
            state_reg <= temp_sensor_pkg::ST_IDLE;
            sda_oe_n  <= 1'b1;
         end else if (start_seen) begin
            // repeated start restarts the frame; pointer is untouched
            state_reg    <= temp_sensor_pkg::ST_ADDR;
            bit_cnt_reg  <= 4'h0;
            gc_reg       <= 1'b0;
            byte_idx_reg <= temp_sensor_pkg::IDX_POINTER;
            sda_oe_n     <= 1'b1;
         end else begin
            unique case (state_reg)
               temp_sensor_pkg::ST_IDLE,
               temp_sensor_pkg::ST_IGNORE: begin
                  sda_oe_n <= 1'b1;
               end
               temp_sensor_pkg::ST_ADDR: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == temp_sensor_pkg::BITS_PER_BYTE) begin
                     bit_cnt_reg <= 4'h0;
                     // reloading: even our address is refused
                     if (reload_bus.busy) begin
                        state_reg <= temp_sensor_pkg::ST_IGNORE;
                     end else if (rx_is_own) begin
                        read_dir_reg <= shift_reg[0];
                        cur_addr_reg <= pointer_reg;
                        pair_reg     <= is_pair_upper(pointer_reg);
                        sda_oe_n     <= 1'b0;
                        state_reg    <= temp_sensor_pkg::ST_ADDR_ACK;
                        if (shift_reg[0]) begin
                           reg_addr <= pointer_reg;
                           reg_rd   <= 1'b1;
                        end
                     end else if (rx_is_gc) begin
                        gc_reg       <= 1'b1;
                        read_dir_reg <= 1'b0;
                        sda_oe_n     <= 1'b0;
                        state_reg    <= temp_sensor_pkg::ST_ADDR_ACK;
                     end else begin
                        state_reg <= temp_sensor_pkg::ST_IGNORE;
                     end
                  end
               end
               temp_sensor_pkg::ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (read_dir_reg) begin
                        // register map answers within the acknowledge slot
                        tx_reg    <= {reg_rdata[6:0], 1'b1};
                        sda_oe_n  <= reg_rdata[7];
                        state_reg <= temp_sensor_pkg::ST_RD_BYTE;
                     end else begin
                        // master drives the data byte
                        sda_oe_n  <= 1'b1;
                        state_reg <= temp_sensor_pkg::ST_WR_BYTE;
                     end
                     bit_cnt_reg <= 4'h0;
                  end
               end
               temp_sensor_pkg::ST_WR_BYTE: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == temp_sensor_pkg::BITS_PER_BYTE) begin
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= temp_sensor_pkg::ST_WR_ACK;
                     sda_oe_n    <= 1'b0;
                     if (gc_reg) begin
                        if (shift_reg == temp_sensor_pkg::GC_RESET_CMD) begin
                           reload_start_reg <= 1'b1;
                        end else begin
                           sda_oe_n  <= 1'b1;
                           state_reg <= temp_sensor_pkg::ST_IGNORE;
                        end
                     end else begin
                        unique case (byte_idx_reg)
                           temp_sensor_pkg::IDX_POINTER: begin
                              pointer_reg  <= shift_reg;
                              cur_addr_reg <= shift_reg;
                              pair_reg     <= is_pair_upper(shift_reg);
                              if (shift_reg == temp_sensor_pkg::SOFT_RESET_PTR) begin
                                 reload_start_reg <= 1'b1;
                              end
                           end
                           temp_sensor_pkg::IDX_FIRST_DATA: begin
                              reg_addr  <= cur_addr_reg;
                              reg_wdata <= shift_reg;
                              reg_wr    <= 1'b1;
                           end
                           temp_sensor_pkg::IDX_SECOND_DATA: begin
                              if (pair_reg) begin
                                 reg_addr  <= cur_addr_reg + 8'h01;
                                 reg_wdata <= shift_reg;
                                 reg_wr    <= 1'b1;
                              end
                           end
                           temp_sensor_pkg::IDX_DISCARD: begin
                              // acknowledged but dropped
                              reg_wr <= 1'b0;
                           end
                        endcase
                        if (byte_idx_reg != temp_sensor_pkg::IDX_DISCARD) begin
                           byte_idx_reg <= byte_idx_reg + 2'h1;
                        end
                     end
                  end
               end
               temp_sensor_pkg::ST_WR_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n  <= 1'b1;
                     // after a reload command the rest of the frame is refused
                     state_reg <= (gc_reg || reload_start_reg || reload_bus.busy) ?
                                  temp_sensor_pkg::ST_IGNORE :
                                  temp_sensor_pkg::ST_WR_BYTE;
                  end
               end
               temp_sensor_pkg::ST_RD_BYTE: begin
                  // bits change only after scl falls
                  if (scl_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_reg == temp_sensor_pkg::BITS_PER_BYTE) begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= temp_sensor_pkg::ST_RD_ACK;
                     end else begin
                        sda_oe_n <= tx_reg[7];
                        tx_reg   <= {tx_reg[6:0], 1'b1};
                     end
                  end
               end
               temp_sensor_pkg::ST_RD_ACK: begin
                  if (scl_rise) begin
                     // only the upper byte of a pair continues
                     more_reg <= ~sda_s & pair_reg;
                     if (!sda_s && pair_reg) begin
                        reg_addr <= cur_addr_reg + 8'h01;
                        reg_rd   <= 1'b1;
                     end
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (more_reg) begin
                        pair_reg  <= 1'b0;
                        tx_reg    <= {reg_rdata[6:0], 1'b1};
                        sda_oe_n  <= reg_rdata[7];
                        state_reg <= temp_sensor_pkg::ST_RD_BYTE;
                     end else begin
                        state_reg <= temp_sensor_pkg::ST_IGNORE;
                     end
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // side outputs
   // registered so each port comes from a flop
   // open drain: sda_oe_n alone decides
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         defaults_reload <= 1'b0;
         alarm_clear     <= 1'b0;
         reload_busy     <= 1'b0;
         sda_out         <= 1'b0;
      end else begin
         defaults_reload <= reload_start_reg;
         alarm_clear     <= reg_rd;
         reload_busy     <= reload_bus.busy | reload_start_reg;
         sda_out         <= 1'b0;
      end
   end

endmodule : temp_sensor_i2c_slave_port
`default_nettype wire

/* File: core/temp_sensor_pkg.sv */
// constants and types shared by the temperature sensor serial slave port
package temp_sensor_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus address
   localparam logic [4:0] ADDR_FIXED_BITS  = 5'h12;
   localparam logic [6:0] GENERAL_CALL     = 7'h00;
   localparam logic [7:0] GC_RESET_CMD     = 8'h06;
   localparam logic [7:0] SOFT_RESET_PTR   = 8'h2F;

   ////////////////////////////////////////////////////////////////////////////
   // upper bytes of the 16-bit register pairs
   localparam logic [7:0] TEMP_UPPER       = 8'h00;
   localparam logic [7:0] HIGH_UPPER       = 8'h04;
   localparam logic [7:0] LOWER_UPPER      = 8'h06;
   localparam logic [7:0] CRIT_UPPER       = 8'h08;
   localparam logic [7:0] POINTER_RESET    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // byte framing
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
   localparam logic [1:0] IDX_POINTER      = 2'h0;
   localparam logic [1:0] IDX_FIRST_DATA   = 2'h1;
   localparam logic [1:0] IDX_SECOND_DATA  = 2'h2;
   localparam logic [1:0] IDX_DISCARD      = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLOCK_PERIOD_NS  = 20;
   localparam int RELOAD_TIME_NS   = 200000;
   // longest time: rounds down
   localparam int RELOAD_CYCLES    = RELOAD_TIME_NS / CLOCK_PERIOD_NS;
   localparam int RELOAD_CNT_W     = 16;

   ////////////////////////////////////////////////////////////////////////////
   // protocol states
   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_ADDR     = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_WR_BYTE  = 8'h08,
      ST_WR_ACK   = 8'h10,
      ST_RD_BYTE  = 8'h20,
      ST_RD_ACK   = 8'h40,
      ST_IGNORE   = 8'h80
   } link_state_e;

endpackage : temp_sensor_pkg

/* File: core/reload_if.sv */
// handshake between the protocol engine and the default reload timer
`timescale 1ns/1ps
`default_nettype none
interface reload_if;
   logic start;
   logic busy;
   modport engine (output start, input busy);
   modport timer  (input start, output busy);
endinterface : reload_if
`default_nettype wire

/* File: core/bit_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] data_in,
   output var  logic [WIDTH-1:0] data_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds the second only
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '1;
         data_out <= '1;
      end else begin
         meta_reg <= data_in;
         data_out <= meta_reg;
      end
   end
endmodule : bit_sync
`default_nettype wire

/* File: core/reload_timer.sv */
// holds busy for the default reload time after a reset command
`timescale 1ns/1ps
`default_nettype none
module reload_timer #(
   parameter int RELOAD_CYCLES = temp_sensor_pkg::RELOAD_CYCLES
) (
   input  wire logic clock,
   input  wire logic rstn,
   reload_if.timer   ctl
);
   localparam int W = temp_sensor_pkg::RELOAD_CNT_W;
   localparam logic [W-1:0] LAST = W'(RELOAD_CYCLES - 1);

   logic [W-1:0] count_reg;
   logic         busy_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         busy_reg  <= 1'b0;
      end else if (ctl.start) begin
         // a new command restarts the full window
         count_reg <= '0;
         busy_reg  <= 1'b1;
      end else if (busy_reg) begin
         if (count_reg == LAST) begin
            busy_reg <= 1'b0;
         end
         count_reg <= count_reg + 1'b1;
      end
   end

   assign ctl.busy = busy_reg;
endmodule : reload_timer
`default_nettype wire

/* File: dv/temp_sensor_asserts.sv */
// concurrent checks on the ports of the temperature sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_asserts #(
   parameter int RELOAD_CYCLES = temp_sensor_pkg::RELOAD_CYCLES
) (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       address_strap_bit0,
   input wire logic       address_strap_bit1,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       defaults_reload,
   input wire logic       alarm_clear,
   input wire logic       reload_busy
);
   int busy_len_reg;
   int since_cmd_reg;

   // since_cmd_reg saturates, so a long quiet run cannot wrap into a false pass
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_len_reg  <= 0;
         since_cmd_reg <= 0;
      end else begin
         busy_len_reg  <= reload_busy ? busy_len_reg + 1 : 0;
         since_cmd_reg <= defaults_reload ? 0 : since_cmd_reg + int'(since_cmd_reg < 99999);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sda_level_a: assert property (sda_out == 1'b0)
      else $error("data output not held low");
   drive_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data drive changed while clock high");
   wr_gap_a: assert property (reg_wr |=> !reg_wr [*6])
      else $error("register writes too close");
   rd_gap_a: assert property (reg_rd |=> !reg_rd [*6])
      else $error("register reads too close");
   alarm_follow_a: assert property (reg_rd |=> alarm_clear)
      else $error("read without alarm clear");
   alarm_cause_a: assert property (alarm_clear |-> $past(reg_rd))
      else $error("alarm clear without read");
   cmd_no_write_a: assert property (reg_wr |-> reg_addr != temp_sensor_pkg::SOFT_RESET_PTR)
      else $error("reset command stored as register write");
   busy_start_a: assert property (defaults_reload |-> ##[1:3] reload_busy)
      else $error("reload without busy");
   no_ack_busy_a: assert property ($fell(sda_oe_n) |-> !reload_busy)
      else $error("line driven during reload");
   busy_len_a: assert property ($fell(reload_busy) |-> busy_len_reg >= RELOAD_CYCLES - 2)
      else $error("reload busy too short");
   busy_max_a: assert property (reload_busy |=> since_cmd_reg <= RELOAD_CYCLES + 4)
      else $error("reload busy too long");

   cover property (reg_rd ##1 alarm_clear);
   cover property (defaults_reload);
   cover property ($fell(reload_busy));
endmodule : temp_sensor_asserts

bind temp_sensor_i2c_slave_port temp_sensor_asserts #(.RELOAD_CYCLES(RELOAD_CYCLES))
   i_temp_sensor_asserts (.clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_strap_bit0(address_strap_bit0),
   .address_strap_bit1(address_strap_bit1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .defaults_reload(defaults_reload), .alarm_clear(alarm_clear), .reload_busy(reload_busy));
`default_nettype wire

/* File: dv/bus_master_model.sv */
// behavioural two-wire bus master on the far side of the sensor port
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input  wire logic clock,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one quarter of a 160 ns bus bit
   task automatic step(input logic c, input logic d);
      scl     <= c;
      sda_drv <= d;
      repeat (2) @(posedge clock);
   endtask : step

   // a repeated start first lifts data while the clock is still low
   task automatic start_cond();
      step(scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : start_cond

   task automatic stop_cond();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop_cond

   // line read late in the high phase, after the slave's drive has settled
   task automatic bit_xfer(input logic b, output logic seen);
      step(1'b0, b);
      step(1'b1, b);
      step(1'b1, b);
      seen = sda_line;
      step(1'b0, b);
   endtask : bit_xfer

   task automatic write_byte(input logic [7:0] d, output logic nack);
      logic x;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], x);
      bit_xfer(1'b1, nack);
   endtask : write_byte

   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, x);
         d = {d[6:0], x};
      end
      bit_xfer(nack, x);
   endtask : read_byte
endmodule : bus_master_model
`default_nettype wire

/* File: dv/test_temp_sensor_i2c_slave_port.sv */
// self-checking bench for the temperature sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_i2c_slave_port;
   localparam int RELOAD = 200;
   localparam int LIMIT  = 30000;
   logic       clock  = 1'b0;
   logic       rstn   = 1'b0;
   logic       strap0 = 1'b0;
   logic       strap1 = 1'b0;
   logic       scl, sda_drv, sda_out, sda_oe_n, reg_wr, reg_rd;
   logic       defaults_reload, alarm_clear, reload_busy;
   logic [7:0] reg_addr, reg_wdata;
   logic [7:0] regs [16];
   wire  logic sda_line = sda_drv & (sda_oe_n | sda_out);
   wire  logic [7:0] reg_rdata = regs[reg_addr[3:0]];
   int         failures, samples_checked, cycles, wr_cnt, rd_cnt, rl_cnt, ac_cnt;

   always #10 clock = ~clock;
   initial regs = '{default: 8'h00};

   // register map stand-in; also counts the port's strobes
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (reg_wr) regs[reg_addr[3:0]] <= reg_wdata;
      wr_cnt <= wr_cnt + int'(reg_wr);
      rd_cnt <= rd_cnt + int'(reg_rd);
      ac_cnt <= ac_cnt + int'(alarm_clear);
      rl_cnt <= rl_cnt + int'(defaults_reload);
      if (defaults_reload) regs <= '{4: 8'h20, 6: 8'h05, 8: 8'h49, 9: 8'h80, 10: 8'h05,
                                     default: 8'h00};
      if (cycles == LIMIT) begin
         failures++;
         complete_run();
      end
   end

   temp_sensor_i2c_slave_port #(.RELOAD_CYCLES(RELOAD)) i_temp_sensor_i2c_slave_port (
      .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .address_strap_bit0(strap0), .address_strap_bit1(strap1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .defaults_reload(defaults_reload), .alarm_clear(alarm_clear),
      .reload_busy(reload_busy));
   bus_master_model i_bus_master_model (.clock(clock), .sda_line(sda_line), .scl(scl),
      .sda_drv(sda_drv));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   // ln bit 0 is the address slot, bit i the slot of byte i; 1 means refused
   task automatic wr_frame(input logic [6:0] a, input logic [31:0] b, input int n,
                           input logic stop, output logic [4:0] ln);
      logic x;
      ln = 5'h1F;
      i_bus_master_model.start_cond();
      i_bus_master_model.write_byte({a, 1'b0}, x);
      ln[0] = x;
      for (int i = 0; i < n; i++) begin
         i_bus_master_model.write_byte(b[31-8*i -: 8], x);
         ln[i+1] = x;
      end
      if (stop) i_bus_master_model.stop_cond();
   endtask : wr_frame

   task automatic rd_frame(input int n, output logic [23:0] d, output logic ln);
      logic [7:0] x;
      d = 24'h0;
      i_bus_master_model.start_cond();
      i_bus_master_model.write_byte({7'h48, 1'b1}, ln);
      for (int i = 0; i < n; i++) begin
         i_bus_master_model.read_byte(i == n - 1, x);
         d = {d[15:0], x};
      end
      i_bus_master_model.stop_cond();
   endtask : rd_frame

   task automatic wait_idle();
      for (int i = 0; i < RELOAD + 50 && reload_busy !== 1'b0; i++) @(posedge clock);
      check({7'h00, reload_busy}, 8'h00);
   endtask : wait_idle

   ////////////////////////////////////////////////////////////////////////////
   // counts down so the straps end at the base address
   task automatic t_address();
      logic [4:0] ln;
      for (int s = 3; s >= 0; s--) begin
         strap0 <= s[0];
         strap1 <= s[1];
         repeat (6) @(posedge clock);
         wr_frame(7'h48 | 7'(s), 32'h0, 0, 1'b1, ln);
         check({7'h00, ln[0]}, 8'h00);
         wr_frame(7'h48 | 7'(s ^ 1), 32'h0, 0, 1'b1, ln);
         check({7'h00, ln[0]}, 8'h01);
         wr_frame(7'h08 | 7'(s), 32'h0, 0, 1'b1, ln);
         check({7'h00, ln[0]}, 8'h01);
      end
      $display("address test done");
   endtask : t_address

   task automatic t_write();
      logic [4:0] ln;
      int         w0;
      w0 = wr_cnt;
      wr_frame(7'h48, 32'h04AABBCC, 4, 1'b1, ln);
      check({3'h0, ln}, 8'h00);
      check(regs[4], 8'hAA);
      check(regs[5], 8'hBB);
      check(8'(wr_cnt - w0), 8'h02);
      w0 = wr_cnt;
      wr_frame(7'h48, 32'h015A7700, 3, 1'b1, ln);
      check(regs[1], 8'h5A);
      check(8'(wr_cnt - w0), 8'h01);
      $display("write test done");
   endtask : t_write

   task automatic t_read();
      logic [4:0]  ln;
      logic [23:0] d;
      logic        l;
      int          r0;
      int          a0;
      wr_frame(7'h48, 32'h04000000, 1, 1'b0, ln);
      r0 = rd_cnt;
      a0 = ac_cnt;
      rd_frame(2, d, l);
      check({7'h00, l}, 8'h00);
      check(d[15:8], 8'hAA);
      check(d[7:0], 8'hBB);
      check(8'(ac_cnt - a0), 8'h02);
      rd_frame(3, d, l);
      check(d[23:16], 8'hAA);
      check(d[7:0], 8'hFF);
      check(8'(rd_cnt - r0), 8'h04);
      wr_frame(7'h48, 32'h01000000, 1, 1'b0, ln);
      rd_frame(1, d, l);
      check(d[7:0], 8'h5A);
      $display("read test done");
   endtask : t_read

   task automatic t_reload(input logic [6:0] a, input logic [7:0] cmd);
      logic [4:0] ln;
      int         r0;
      r0 = rl_cnt;
      wr_frame(a, {cmd, 24'h0}, 1, 1'b1, ln);
      check({6'h00, ln[1:0]}, 8'h00);
      check(8'(rl_cnt - r0), 8'h01);
      wr_frame(7'h48, 32'h0, 0, 1'b1, ln);
      check({7'h00, ln[0]}, 8'h01);
      wait_idle();
      check(regs[4], 8'h20);
      wr_frame(7'h48, 32'h0, 0, 1'b1, ln);
      check({7'h00, ln[0]}, 8'h00);
      wr_frame(7'h00, 32'h07000000, 1, 1'b1, ln);
      check({6'h00, ln[1:0]}, 8'h02);
      check(8'(rl_cnt - r0), 8'h01);
      $display("reload test done");
   endtask : t_reload

   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      t_address();
      t_write();
      t_read();
      t_reload(7'h48, temp_sensor_pkg::SOFT_RESET_PTR);
      t_reload(7'h00, temp_sensor_pkg::GC_RESET_CMD);
      complete_run();
   end
endmodule : test_temp_sensor_i2c_slave_port
`default_nettype wire
